// file: shared/thci_map.svh
// register offsets, field positions, codes and reset values of the tape command interface
// Overview of operation
// - vector bit 9 shows busy while a command runs, clear when idle
// - vector bits 8,10..14 report intervention, refusal, data, skip, overrun, fifo faults
// - command word zero is idle; device keeps waiting
// - code 0001 reads one block, backspacing and retrying up to the limit
// - code 0002 writes one block; on failure backspace, erase, retry
// - code 0003 rewinds to logical start of tape
// - low codes 04..07 skip count of blocks or files fwd or back
// - code 0008 writes a file mark
// - code 0009 loads to logical start track 0; 000A returns to load point
// - low code 0B selects drive 0..3 from upper byte
// - low code 0C sets retry limit 0..15; default is 10
// - low code 0E rewinds and selects track 0..3
// - low code 0F sets mode; mode 1 keeps tracks separate
// - mode 0 treats tape as one long track; power-on default
// - code 0010 runs self-check of rom, fifo and host ports
// - status low byte bits 0..4,6,7 carry condition flags; bit 5 unused
// - status bits 8..11 show protect, logical start, logical end, retry used
// - status bits 12..13 drive address, 14..15 track address
// - on nonzero command clear pending, set busy, validate first
// - on finish zero command, set pending, request interrupt; ack sets in-service
// - host vector read clears in-service; device clears pending and busy
`ifndef THCI_MAP_SVH
`define THCI_MAP_SVH
`define THCI_OFS_VECTOR 4'h0
`define THCI_OFS_COMMAND 4'h1
`define THCI_OFS_STATUS 4'h2
`define THCI_OFS_MIC 4'h3
`define THCI_OFS_DRIVE_IN 4'h4
`define THCI_VEC_INTERVENTION_FLAG 8
`define THCI_VEC_BUSY 9
`define THCI_VEC_CMDREF 10
`define THCI_VEC_DATA 11
`define THCI_VEC_SKIP 12
`define THCI_VEC_OVR 13
`define THCI_VEC_FIFO 14
`define THCI_MIC_MIE 0
`define THCI_MIC_IE 1
`define THCI_MIC_DLC 2
`define THCI_MIC_IUS 6
`define THCI_MIC_IP 7
`define THCI_CMD_IDLE 8'h00
`define THCI_CMD_READ 8'h01
`define THCI_CMD_WRITE 8'h02
`define THCI_CMD_REWIND 8'h03
`define THCI_CMD_SKIP_BLOCKS_FWD_CMD 8'h04
`define THCI_CMD_SKBB 8'h05
`define THCI_CMD_SKIP_FILES_FWD_CMD 8'h06
`define THCI_CMD_SKFB 8'h07
`define THCI_CMD_FMARK 8'h08
`define THCI_CMD_LOAD 8'h09
`define THCI_CMD_EJECT 8'h0A
`define THCI_CMD_DRIVE 8'h0B
`define THCI_CMD_RETRY 8'h0C
`define THCI_CMD_TRACK 8'h0E
`define THCI_CMD_MODE 8'h0F
`define THCI_CMD_CHECK 8'h10
`define THCI_RETRY_DEFAULT 4'hA
`define THCI_OP_TICKS 8'h08
`define THCI_VEC_LOW_DEFAULT 8'h40
`endif

// file: shared/thci_pkg.sv
// types of the tape command interface
package thci_pkg;
    typedef enum logic [6:0]
    {
        THCI_IDLE = 7'h01,
        THCI_CHECK = 7'h02,
        THCI_MOVE = 7'h04,
        THCI_RECOVER = 7'h08,
        THCI_COUNT = 7'h10,
        THCI_DONE = 7'h20,
        THCI_WAIT = 7'h40
    } thci_state_t;

    // drive-side inputs, not yet synchronised; the interface passes them through two flops before use
    typedef struct packed {
        logic no_cart;
        logic protect;
        logic op_fail;
        logic filemark;
        logic blank;
        logic hw_fault;
        logic at_start;
        logic at_end;
    } thci_drive_t;

    // motion request driven towards the tape drive
    typedef struct packed {
        logic rewind;
        logic fwd;
        logic rev;
        logic wr_en;
        logic erase;
        logic to_load_point;
        logic [1:0] drive;
        logic [1:0] track;
    } thci_motion_t;
endpackage : thci_pkg

// file: src/thci_top.sv
// tape host command interface: avalon-mm registers, command decode and sequencing
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "thci_map.svh"
module thci_top #(
    parameter int OP_TICKS = 8
)
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [1:0] avs_byteenable_in,
    input wire logic [15:0] avs_writedata_in,
    output logic [15:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire thci_pkg::thci_drive_t drive_in,
    input wire logic int_ack_in,
    output thci_pkg::thci_motion_t motion_out,
    output logic irq_out
);
    import thci_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    thci_drive_t drv_meta;
    thci_drive_t drv;
    logic ack_meta;
    logic ack_sync;
    logic ack_prev;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            drv_meta <= '0;
            drv <= '0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            ack_prev <= 1'b0;
        end
        else
        begin
            drv_meta <= drive_in;
            drv <= drv_meta;
            ack_meta <= int_ack_in;
            ack_sync <= ack_meta;
            ack_prev <= ack_sync;
        end
    end

    wire ack_rise = ack_sync && !ack_prev;

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    thci_state_t state;
    logic [15:0] command_word;
    logic [7:0] vec_low;
    logic [6:0] err_flags;
    logic [7:0] cond_flags;
    logic [2:0] mic_ctrl;
    logic in_service;
    logic pending;
    logic busy;
    logic [3:0] retry_limit;
    logic [3:0] retries;
    logic retry_used;
    logic mode_one;
    logic [1:0] drive_sel;
    logic [1:0] track_sel;
    logic [7:0] skip_left;
    logic [7:0] tick;
    logic [7:0] op;

    wire bus_wr = avs_write_in && !avs_waitrequest_out;
    wire bus_rd = avs_read_in && !avs_waitrequest_out;

    // ----------------------------------------
    // command validity
    // ----------------------------------------
    function automatic logic cmd_valid(input logic [15:0] c);
        logic ok;
        ok = 1'b0;
        unique case (c[7:0])
            `THCI_CMD_READ, `THCI_CMD_WRITE, `THCI_CMD_REWIND, `THCI_CMD_FMARK,
            `THCI_CMD_LOAD, `THCI_CMD_EJECT, `THCI_CMD_CHECK:
                ok = (c[15:8] == 8'h00);
            `THCI_CMD_SKIP_BLOCKS_FWD_CMD, `THCI_CMD_SKBB, `THCI_CMD_SKIP_FILES_FWD_CMD, `THCI_CMD_SKFB:
                ok = 1'b1;
            `THCI_CMD_DRIVE, `THCI_CMD_TRACK:
                ok = (c[15:8] <= 8'h03);
            `THCI_CMD_RETRY:
                ok = (c[15:8] <= 8'h0F);
            `THCI_CMD_MODE:
                ok = (c[15:8] <= 8'h01);
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction : cmd_valid

    function automatic logic is_motion(input logic [7:0] c);
        return (c >= `THCI_CMD_READ && c <= `THCI_CMD_EJECT) || c == `THCI_CMD_TRACK;
    endfunction : is_motion

    // ----------------------------------------
    // avalon slave: one wait cycle per access
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            avs_waitrequest_out <= 1'b1;
        else
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            avs_readdata_out <= 16'h0000;
        else if (avs_read_in && avs_waitrequest_out)
        begin
            unique case (avs_address_in)
                `THCI_OFS_VECTOR:
                    avs_readdata_out <= {1'b0, err_flags[6:2], busy, err_flags[0], vec_low};
                `THCI_OFS_COMMAND:
                    avs_readdata_out <= command_word;
                `THCI_OFS_STATUS:
                    avs_readdata_out <= {track_sel, drive_sel, retry_used, drv.at_end,
                        drv.at_start, drv.protect, cond_flags};
                `THCI_OFS_MIC:
                    avs_readdata_out <= {8'h00, pending, in_service, 3'b000, mic_ctrl};
                default:
                    avs_readdata_out <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // interrupt control register
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            mic_ctrl <= 3'b000;
            vec_low <= `THCI_VEC_LOW_DEFAULT;
        end
        else if (bus_wr && avs_address_in == `THCI_OFS_MIC && avs_byteenable_in[0])
            mic_ctrl <= avs_writedata_in[2:0];
        else if (bus_wr && avs_address_in == `THCI_OFS_VECTOR && avs_byteenable_in[0])
            vec_low <= avs_writedata_in[7:0];
    end

    // in-service: set on acknowledge, cleared by host vector read
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            in_service <= 1'b0;
        else if (state == THCI_WAIT && ack_rise)
            in_service <= 1'b1;
        else if (bus_rd && avs_address_in == `THCI_OFS_VECTOR)
            in_service <= 1'b0;
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            irq_out <= 1'b0;
        else
            irq_out <= pending && !in_service && mic_ctrl[`THCI_MIC_MIE]
                && mic_ctrl[`THCI_MIC_IE] && state == THCI_WAIT;
    end

    // ----------------------------------------
    // command sequencer
    // ----------------------------------------
    wire [7:0] code = command_word[7:0];
    wire host_cmd_wr = bus_wr && avs_address_in == `THCI_OFS_COMMAND;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state <= THCI_IDLE;
            command_word <= 16'h0000;
            busy <= 1'b0;
            pending <= 1'b0;
            err_flags <= '0;
            cond_flags <= 8'h00;
            retry_limit <= `THCI_RETRY_DEFAULT;
            retries <= 4'h0;
            retry_used <= 1'b0;
            mode_one <= 1'b0;
            drive_sel <= 2'b00;
            track_sel <= 2'b00;
            skip_left <= 8'h00;
            tick <= 8'h00;
            op <= 8'h00;
        end
        else
        begin
            unique case (state)
                THCI_IDLE:
                begin
                    if (host_cmd_wr)
                    begin
                        if (avs_byteenable_in[0])
                            command_word[7:0] <= avs_writedata_in[7:0];
                        if (avs_byteenable_in[1])
                            command_word[15:8] <= avs_writedata_in[15:8];
                    end
                    else if (command_word != 16'h0000)
                    begin
                        pending <= 1'b0;
                        busy <= 1'b1;
                        err_flags <= '0;
                        cond_flags <= 8'h00;
                        retries <= 4'h0;
                        retry_used <= 1'b0;
                        state <= THCI_CHECK;
                    end
                end
                THCI_CHECK:
                begin
                    op <= code;
                    tick <= 8'(OP_TICKS);
                    skip_left <= command_word[15:8];
                    if (!cmd_valid(command_word))
                    begin
                        err_flags[`THCI_VEC_CMDREF - 8] <= 1'b1;
                        cond_flags[3] <= 1'b1;
                        state <= THCI_DONE;
                    end
                    else if (is_motion(code) && drv.no_cart)
                    begin
                        err_flags[`THCI_VEC_INTERVENTION_FLAG - 8] <= 1'b1;
                        cond_flags[0] <= 1'b1;
                        state <= THCI_DONE;
                    end
                    else if ((code == `THCI_CMD_WRITE || code == `THCI_CMD_FMARK)
                        && drv.protect)
                    begin
                        cond_flags[4] <= 1'b1;
                        err_flags[`THCI_VEC_INTERVENTION_FLAG - 8] <= 1'b1;
                        state <= THCI_DONE;
                    end
                    else
                    begin
                        unique case (code)
                            `THCI_CMD_DRIVE:
                            begin
                                drive_sel <= command_word[9:8];
                                state <= THCI_DONE;
                            end
                            `THCI_CMD_RETRY:
                            begin
                                retry_limit <= command_word[11:8];
                                state <= THCI_DONE;
                            end
                            `THCI_CMD_MODE:
                            begin
                                mode_one <= command_word[8];
                                state <= THCI_DONE;
                            end
                            `THCI_CMD_TRACK:
                            begin
                                track_sel <= command_word[9:8];
                                state <= THCI_MOVE;
                            end
                            `THCI_CMD_LOAD:
                            begin
                                track_sel <= 2'b00;
                                state <= THCI_MOVE;
                            end
                            `THCI_CMD_REWIND:
                            begin
                                if (!mode_one)
                                    track_sel <= 2'b00;
                                state <= THCI_MOVE;
                            end
                            `THCI_CMD_SKIP_BLOCKS_FWD_CMD, `THCI_CMD_SKBB, `THCI_CMD_SKIP_FILES_FWD_CMD, `THCI_CMD_SKFB:
                                state <= THCI_COUNT;
                            default:
                                state <= THCI_MOVE;
                        endcase
                    end
                end
                THCI_MOVE:
                begin
                    if (tick != 8'h00)
                        tick <= tick - 8'h01;
                    else if (drv.hw_fault)
                    begin
                        cond_flags[2] <= 1'b1;
                        err_flags[`THCI_VEC_FIFO - 8] <= (op == `THCI_CMD_CHECK);
                        state <= THCI_DONE;
                    end
                    else if ((op == `THCI_CMD_READ || op == `THCI_CMD_WRITE) && drv.op_fail)
                    begin
                        if (retries < retry_limit)
                        begin
                            retries <= retries + 4'h1;
                            retry_used <= 1'b1;
                            tick <= 8'(OP_TICKS);
                            state <= THCI_RECOVER;
                        end
                        else
                        begin
                            err_flags[`THCI_VEC_DATA - 8] <= 1'b1;
                            state <= THCI_DONE;
                        end
                    end
                    else
                    begin
                        if (op == `THCI_CMD_READ)
                        begin
                            cond_flags[1] <= drv.filemark;
                            cond_flags[7] <= drv.blank;
                        end
                        state <= THCI_DONE;
                    end
                end
                THCI_RECOVER:
                begin
                    // backspace, and for writes erase, before the retry
                    if (tick != 8'h00)
                        tick <= tick - 8'h01;
                    else
                    begin
                        tick <= 8'(OP_TICKS);
                        state <= THCI_MOVE;
                    end
                end
                THCI_COUNT:
                begin
                    // skips stop at a logical end; in mode 1 that is the track end
                    if (skip_left == 8'h00)
                        state <= THCI_DONE;
                    else if ((op[0] == 1'b0 && drv.at_end) || (op[0] && drv.at_start))
                    begin
                        err_flags[`THCI_VEC_SKIP - 8] <= 1'b1;
                        state <= THCI_DONE;
                    end
                    else if (tick != 8'h00)
                        tick <= tick - 8'h01;
                    else
                    begin
                        if (op <= `THCI_CMD_SKBB && drv.filemark)
                            cond_flags[1] <= 1'b1;
                        if (op >= `THCI_CMD_SKIP_FILES_FWD_CMD && !drv.filemark)
                            tick <= 8'(OP_TICKS); // file continues until a mark
                        else
                        begin
                            skip_left <= skip_left - 8'h01;
                            tick <= 8'(OP_TICKS);
                        end
                    end
                end
                THCI_DONE:
                begin
                    command_word <= 16'h0000;
                    pending <= 1'b1;
                    state <= THCI_WAIT;
                end
                THCI_WAIT:
                begin
                    if (bus_rd && avs_address_in == `THCI_OFS_VECTOR && in_service)
                    begin
                        pending <= 1'b0;
                        busy <= 1'b0;
                        state <= THCI_IDLE;
                    end
                end
                default:
                    state <= THCI_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // motion outputs
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            motion_out <= '0;
        else
        begin
            motion_out.drive <= drive_sel;
            motion_out.track <= track_sel;
            motion_out.rewind <= state == THCI_MOVE && (op == `THCI_CMD_REWIND
                || op == `THCI_CMD_TRACK || op == `THCI_CMD_LOAD);
            motion_out.to_load_point <= state == THCI_MOVE && op == `THCI_CMD_EJECT;
            motion_out.fwd <= (state == THCI_MOVE && (op == `THCI_CMD_READ
                || op == `THCI_CMD_WRITE || op == `THCI_CMD_FMARK))
                || (state == THCI_COUNT && op[0] == 1'b0);
            motion_out.rev <= state == THCI_RECOVER || (state == THCI_COUNT && op[0]);
            motion_out.wr_en <= state == THCI_MOVE && (op == `THCI_CMD_WRITE
                || op == `THCI_CMD_FMARK);
            motion_out.erase <= state == THCI_RECOVER && op == `THCI_CMD_WRITE;
        end
    end
endmodule : thci_top

// file: bench/thci_top_asserts.sv
// port checker of the tape command interface
`timescale 1ns/1ps
module thci_top_asserts
import thci_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [15:0] avs_writedata_in,
    input wire logic [15:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire thci_pkg::thci_motion_t motion_out,
    input wire logic int_ack_in,
    input wire logic irq_out
);
    // ------
    // properties
    // ------
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    logic cmd_take;
    logic rd_take;
    logic [4:0] moving;
    logic [15:0] cmd_word;
    assign cmd_take = avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h1;
    assign rd_take = avs_read_in && !avs_waitrequest_out;
    assign moving = {motion_out.rewind, motion_out.fwd, motion_out.rev, motion_out.wr_en,
        motion_out.erase};
    // last command kept so later motion can be tied back to it
    always_ff @(posedge mclk_in or negedge resetn_in)
        if (!resetn_in)
            cmd_word <= 16'h0000;
        else if (cmd_take)
            cmd_word <= avs_writedata_in;
    property p_vec_top; rd_take && avs_address_in == 4'h0 |-> !avs_readdata_out[15]; endproperty
    a_vec_top: assert property (p_vec_top) else $error("vector bit 15 set");
    property p_stat_gap; rd_take && avs_address_in == 4'h2 |-> !avs_readdata_out[5]; endproperty
    a_stat_gap: assert property (p_stat_gap) else $error("status bit 5 set");
    property p_stat_drive;
        rd_take && avs_address_in == 4'h2 |-> avs_readdata_out[13:12] == motion_out.drive;
    endproperty
    a_stat_drive: assert property (p_stat_drive) else $error("status drive differs");
    property p_stat_track;
        rd_take && avs_address_in == 4'h2 |-> avs_readdata_out[15:14] == motion_out.track;
    endproperty
    a_stat_track: assert property (p_stat_track) else $error("status track differs");
    property p_nop_still;
        cmd_take && avs_writedata_in == 16'h0000 && moving == 5'h00 |=> moving == 5'h00 [*8];
    endproperty
    a_nop_still: assert property (p_nop_still) else $error("idle command moved tape");
    property p_bad_still;
        cmd_take && avs_writedata_in[7:0] == 8'h0D && moving == 5'h00 |=> moving == 5'h00 [*8];
    endproperty
    a_bad_still: assert property (p_bad_still) else $error("bad code moved tape");
    property p_drive_sel;
        cmd_take && avs_writedata_in[7:0] == 8'h0B && avs_writedata_in[15:10] == 6'h00
        |=> ##[0:200] motion_out.drive == cmd_word[9:8];
    endproperty
    a_drive_sel: assert property (p_drive_sel) else $error("drive not selected");
    property p_track_sel;
        cmd_take && avs_writedata_in[7:0] == 8'h0E && avs_writedata_in[15:10] == 6'h00
        |=> ##[0:200] motion_out.track == cmd_word[9:8];
    endproperty
    a_track_sel: assert property (p_track_sel) else $error("track not selected");
    property p_ack_drop; irq_out && $rose(int_ack_in) |-> ##[1:8] !irq_out; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("irq kept after ack");
    property p_one_way; !(motion_out.fwd && motion_out.rev); endproperty
    a_one_way: assert property (p_one_way) else $error("fwd and rev together");
endmodule : thci_top_asserts
bind thci_top thci_top_asserts chk_u (.mclk_in, .resetn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .motion_out,
    .int_ack_in, .irq_out);

// file: bench/thci_drive_model.sv
// behavioural tape drive answering motion requests
`timescale 1ns/1ps
module thci_drive_model
import thci_pkg::*;
(
    input wire logic mclk_in,
    input wire thci_pkg::thci_motion_t motion_in,
    input wire logic no_cart_in,
    input wire logic protect_in,
    input wire logic fail_in,
    output thci_pkg::thci_drive_t drive_out
);
    // ------
    // drive
    // ------
    logic at_start = 1'b0;
    // no file marks on this tape, so file skips are only run with count 0
    always_ff @(posedge mclk_in)
        if (motion_in.rewind || motion_in.to_load_point)
            at_start <= 1'b1;
        else if (motion_in.fwd)
            at_start <= 1'b0;
    assign drive_out = '{no_cart: no_cart_in, protect: protect_in, op_fail: fail_in,
        filemark: 1'b0, blank: 1'b0, hw_fault: 1'b0, at_start: at_start, at_end: 1'b0};
endmodule : thci_drive_model

// file: bench/thci_top_test.sv
// self-checking testbench of the tape command interface
`timescale 1ns/1ps
module thci_top_test;
import thci_pkg::*;
    // ------
    // stimulus and checks
    // ------
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic ack = 1'b0;
    logic no_cart = 1'b0;
    logic write_locked_flag = 1'b0;
    logic fail = 1'b0;
    logic [15:0] rdata;
    logic waitreq;
    logic irq;
    logic [15:0] v;
    logic [15:0] s;
    thci_drive_t drv;
    thci_motion_t mot;
    int err_count = 0;
    int cmp_count = 0;
    initial forever #4 mclk_in = ~mclk_in;
    thci_top #(.OP_TICKS(2)) dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(2'h3),
        .avs_writedata_in(wd), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .drive_in(drv), .int_ack_in(ack), .motion_out(mot), .irq_out(irq));
    thci_drive_model drv_u (.mclk_in(mclk_in), .motion_in(mot), .no_cart_in(no_cart),
        .protect_in(write_locked_flag), .fail_in(fail), .drive_out(drv));
    task give_verdict;
        $display("mismatches %0d of %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task check(input string what, input logic [15:0] seen, input logic [15:0] mask,
        input logic [15:0] exp);
        cmp_count++;
        if ((seen & mask) !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen & mask);
        end
    endtask : check
    // every wait is bounded; running out ends the run
    task bus(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        int n;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        do
        begin
            @(posedge mclk_in);
            n++;
        end
        while (waitreq !== 1'b0 && n < 4000);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        check("handshake", 16'(n < 4000), 16'h0001, 16'h0001);
        if (n >= 4000)
            give_verdict();
        @(posedge mclk_in);
    endtask : bus
    task run(input logic [15:0] c, output logic [15:0] vec);
        logic [15:0] q;
        repeat (3) @(posedge mclk_in);
        bus(1'b1, 4'h1, c, q);
        bus(1'b0, 4'h0, 16'h0000, q);
        check("busy", q, 16'h0200, 16'h0200);
        for (int k = 0; irq !== 1'b1 && k < 400; k++)
            bus(1'b0, 4'h3, 16'h0000, q);
        check("irq", 16'(irq), 16'h0001, 16'h0001);
        if (irq !== 1'b1)
            give_verdict();
        ack <= 1'b1;
        repeat (4) @(posedge mclk_in);
        ack <= 1'b0;
        repeat (4) @(posedge mclk_in);
        bus(1'b0, 4'h0, 16'h0000, vec);
        bus(1'b0, 4'h0, 16'h0000, q);
        check("idle", q, 16'h0200, 16'h0000);
        bus(1'b0, 4'h2, 16'h0000, s);
    endtask : run
    task t_reset;
        logic [15:0] q;
        bus(1'b0, 4'h0, 16'h0000, q);
        check("vector", q, 16'hFFFF, 16'h0040);
        bus(1'b1, 4'h2, 16'hFFFF, q);
        bus(1'b0, 4'h2, 16'h0000, q);
        check("units", q, 16'hF000, 16'h0000);
        bus(1'b0, 4'h7, 16'h0000, q);
        check("unmapped", q, 16'hFFFF, 16'h0000);
        bus(1'b1, 4'h3, 16'h0003, q);
        bus(1'b0, 4'h3, 16'h0000, q);
        check("intctl", q, 16'h00C7, 16'h0003);
        bus(1'b1, 4'h1, 16'h0000, q);
        bus(1'b0, 4'h0, 16'h0000, q);
        check("nop", q, 16'h0200, 16'h0000);
    endtask : t_reset
    task t_units;
        run(16'h020B, v);
        check("drive", s, 16'h3000, 16'h2000);
        run(16'h030E, v);
        check("track", s, 16'hC000, 16'hC000);
    endtask : t_units
    task t_refuse;
        static logic [15:0] bad [6] = '{16'h000D, 16'h0011, 16'h100C, 16'h040B, 16'h040E,
            16'h020F};
        foreach (bad[i])
        begin
            run(bad[i], v);
            check("refused", v, 16'h0400, 16'h0400);
            check("invalid", s, 16'h0008, 16'h0008);
        end
    endtask : t_refuse
    task t_codes;
        static logic [15:0] ok [14] = '{16'h0001, 16'h0002, 16'h0003, 16'h0304, 16'h0005,
            16'h0006,
            16'h0007, 16'h0008, 16'h000A, 16'h0009, 16'h0F0C, 16'h010F, 16'h000F, 16'h0010};
        foreach (ok[i])
        begin
            run(ok[i], v);
            // busy still shows in the vector read that ends the command
            check("clean", v, 16'hFD00, 16'h0000);
        end
    endtask : t_codes
    task t_retry;
        run(16'h020C, v);
        fail <= 1'b1;
        run(16'h0001, v);
        check("read fail", v, 16'h0800, 16'h0800);
        check("retried", s, 16'h0800, 16'h0800);
        run(16'h0002, v);
        check("write fail", v, 16'h0800, 16'h0800);
        run(16'h000C, v);
        run(16'h0001, v);
        check("no retry", s, 16'h0800, 16'h0000);
        fail <= 1'b0;
    endtask : t_retry
    task t_flags;
        no_cart <= 1'b1;
        run(16'h0003, v);
        check("intervene", v, 16'h0100, 16'h0100);
        check("no cart", s, 16'h0001, 16'h0001);
        no_cart <= 1'b0;
        write_locked_flag <= 1'b1;
        run(16'h0008, v);
        check("locked", s, 16'h0110, 16'h0110);
        write_locked_flag <= 1'b0;
        run(16'h0003, v);
        check("at start", s, 16'h0200, 16'h0200);
    endtask : t_flags
    initial
    begin
        repeat (5) @(posedge mclk_in);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_units();
        t_refuse();
        t_codes();
        t_retry();
        t_flags();
        give_verdict();
    end
endmodule : thci_top_test
